// File: common/tscc_regs.vh
// register map, field positions, reset values and timing figures of the
// touch sensor configuration block; definitions only
`ifndef TSCC_REGS_VH
`define TSCC_REGS_VH

// register indices; byte address is four times the index
`define TSCC_IDX_SCALE 8'h1f
`define TSCC_IDX_GCFG 8'h20
`define TSCC_IDX_CHEN 8'h21
`define TSCC_IDX_TCFG 8'h22
`define TSCC_IDX_NOISE 8'h0a
`define TSCC_IDX_ISTAT 8'h30
`define TSCC_IDX_IMASK 8'h31

// reset values
`define TSCC_RST_SCALE 4'hf
`define TSCC_RST_GCFG 8'h20
`define TSCC_RST_CHEN 8'hff
`define TSCC_RST_TCFG 8'ha4
`define TSCC_RST_IMASK 4'h0

// global configuration fields
`define TSCC_GCFG_TIMEOUT 7
`define TSCC_GCFG_WAKE 6
`define TSCC_GCFG_DIGBYP 5
`define TSCC_GCFG_ANABYP 4
`define TSCC_GCFG_HOLDEN 3
`define TSCC_GCFG_MASK 8'hf8

// interrupt status bits
`define TSCC_IS_BUSTO 0
`define TSCC_IS_BUSIDLE 1
`define TSCC_IS_HOLD 2
`define TSCC_IS_WAKE 3

// scale limit
`define TSCC_SCALE_MAX 4'h8

// timing figures
`define TSCC_CLK_KHZ 40000
`define TSCC_BUS_LOW_MS 30
`define TSCC_BUS_IDLE_US 150
`define TSCC_US_PER_MS 1000
`define TSCC_RPT_STEP_MS 10'd35
`define TSCC_SLOT_CYC 16'h0100

// hold time before recalibration, ms per code
`define TSCC_HOLD_0 14'd560
`define TSCC_HOLD_1 14'd840
`define TSCC_HOLD_2 14'd1120
`define TSCC_HOLD_3 14'd1400
`define TSCC_HOLD_4 14'd1680
`define TSCC_HOLD_5 14'd2240
`define TSCC_HOLD_6 14'd2800
`define TSCC_HOLD_7 14'd3360
`define TSCC_HOLD_8 14'd3920
`define TSCC_HOLD_9 14'd4480
`define TSCC_HOLD_A 14'd5600
`define TSCC_HOLD_B 14'd6720
`define TSCC_HOLD_C 14'd7840
`define TSCC_HOLD_D 14'd8906
`define TSCC_HOLD_E 14'd10080
`define TSCC_HOLD_F 14'd11200

`endif

// File: design/tscc_bus_watch.v
// serial bus clock-low timeout and both-high idle watch
// assumes scl and sda already synchronised to clk_i
`timescale 1ns/10ps
`include "tscc_regs.vh"
module tscc_bus_watch #(
   parameter LOW_CYCLES = 1200000,
   parameter IDLE_CYCLES = 6000
) (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // control and line levels
   input wire enable_i,
   input wire scl_i,
   input wire sda_i,
   // events
   output reg timeout_o,
   output reg idle_o
);
   // limits arrive as 32-bit integers, counters are only 21 bits
   localparam [31:0] LOW_W = LOW_CYCLES;
   localparam [31:0] IDLE_W = IDLE_CYCLES;
   localparam [20:0] LOW_LIM = LOW_W[20:0];
   localparam [20:0] IDLE_LIM = IDLE_W[20:0];
   reg [20:0] low_cnt;
   reg [20:0] idle_cnt;
   reg low_done;
   reg idle_done;

   // counters stay cleared while disabled, so no event can fire
   always @(posedge clk_i) begin
      if (rst_i || !enable_i) begin
         low_cnt <= 21'h000000;
         idle_cnt <= 21'h000000;
         low_done <= 1'b0;
         idle_done <= 1'b0;
         timeout_o <= 1'b0;
         idle_o <= 1'b0;
      end else begin
         timeout_o <= 1'b0;
         idle_o <= 1'b0;
         if (scl_i) begin
            low_cnt <= 21'h000000;
            low_done <= 1'b0;
         end else if (!low_done) begin
            if (low_cnt == LOW_LIM) begin
               timeout_o <= 1'b1;
               low_done <= 1'b1;
            end else begin
               low_cnt <= low_cnt + 21'h000001;
            end
         end
         if (!(scl_i && sda_i)) begin
            idle_cnt <= 21'h000000;
            idle_done <= 1'b0;
         end else if (!idle_done) begin
            if (idle_cnt == IDLE_LIM) begin
               idle_o <= 1'b1;
               idle_done <= 1'b1;
            end else begin
               idle_cnt <= idle_cnt + 21'h000001;
            end
         end
      end
   end
endmodule // tscc_bus_watch

// File: design/tscc_config.v
// configuration and option logic of an eight-channel touch controller
// assumes a classic wishbone master, analog front end on clk_i,
// serial bus and wake pins asynchronous to clk_i
`timescale 1ns/10ps
`include "tscc_regs.vh"
module tscc_config #(
   parameter BUS_LOW_CYCLES = `TSCC_BUS_LOW_MS * `TSCC_CLK_KHZ,
   parameter BUS_IDLE_CYCLES = `TSCC_BUS_IDLE_US * `TSCC_CLK_KHZ / `TSCC_US_PER_MS,
   parameter MS_CYCLES = `TSCC_CLK_KHZ
) (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_sel_i,
   input wire [9:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // analog front end, same clock
   input wire [15:0] base_raw_i,
   input wire [7:0] touch_raw_i,
   input wire [7:0] noise_raw_i,
   input wire [7:0] ana_err_i,
   input wire [7:0] grouped_i,
   input wire cal_active_i,
   input wire auto_repeat_i,
   // power state
   input wire standby_i,
   input wire deep_sleep_i,
   // serial bus pins
   input wire scl_i,
   input wire sda_i,
   // wake pin, two-way
   input wire wake_i,
   output reg wake_o,
   output reg wake_oe_n_o,
   // results
   output reg [15:0] base_count_o,
   output reg [7:0] touch_o,
   output reg [7:0] recal_use_o,
   output reg [7:0] ana_retry_o,
   output reg [7:0] hold_recal_o,
   output reg [7:0] sample_o,
   output reg repeat_o,
   output reg bus_reset_o,
   output reg wake_exit_o,
   output reg irq_o
);
   localparam [31:0] MS_W = MS_CYCLES - 1;
   localparam [15:0] MS_LIM = MS_W[15:0];
   localparam [15:0] SLOT_LIM = `TSCC_SLOT_CYC - 16'h0001;

   // registers
   reg [3:0] base_scale;
   reg [7:0] global_configuration;
   reg [7:0] channel_sample_enable;
   reg [7:0] channel_timing_config;
   reg [3:0] int_status;
   reg [3:0] int_mask;
   reg [7:0] ana_flag;

   // synchronisers
   reg scl_m, scl_s, sda_m, sda_s, wake_m, wake_s;

   // timing
   reg [15:0] ms_cnt;
   reg ms_tick;
   reg [15:0] slot_cnt;
   reg [2:0] slot_ch;
   reg [9:0] rpt_ms;
   reg wake_drive;

   wire bus_to;
   wire bus_idle;
   wire [7:0] reg_idx = wb_adr_i[9:2];
   wire wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
   wire rd_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire [7:0] wdat = wb_dat_i[7:0];
   wire [3:0] hold_code = channel_timing_config[7:4];
   wire [3:0] rpt_code = channel_timing_config[3:0];
   wire dig_bypass = global_configuration[`TSCC_GCFG_DIGBYP];
   wire ana_bypass = global_configuration[`TSCC_GCFG_ANABYP];
   wire hold_en = global_configuration[`TSCC_GCFG_HOLDEN];
   wire wake_cfg = global_configuration[`TSCC_GCFG_WAKE];
   wire [7:0] touch_ok = touch_raw_i & (~ana_flag | {8{ana_bypass}});
   wire [9:0] rpt_lim = ({6'h00, rpt_code} + 10'h001) * `TSCC_RPT_STEP_MS;
   reg [3:0] next_status;
   reg [7:0] rd_val;
   reg [13:0] hold_ms;

   // decoded hold time in ms
   always @* begin
      case (hold_code)
         4'h0: hold_ms = `TSCC_HOLD_0;
         4'h1: hold_ms = `TSCC_HOLD_1;
         4'h2: hold_ms = `TSCC_HOLD_2;
         4'h3: hold_ms = `TSCC_HOLD_3;
         4'h4: hold_ms = `TSCC_HOLD_4;
         4'h5: hold_ms = `TSCC_HOLD_5;
         4'h6: hold_ms = `TSCC_HOLD_6;
         4'h7: hold_ms = `TSCC_HOLD_7;
         4'h8: hold_ms = `TSCC_HOLD_8;
         4'h9: hold_ms = `TSCC_HOLD_9;
         4'ha: hold_ms = `TSCC_HOLD_A;
         4'hb: hold_ms = `TSCC_HOLD_B;
         4'hc: hold_ms = `TSCC_HOLD_C;
         4'hd: hold_ms = `TSCC_HOLD_D;
         4'he: hold_ms = `TSCC_HOLD_E;
         default: hold_ms = `TSCC_HOLD_F;
      endcase
   end

   // read mux
   always @* begin
      case (reg_idx)
         `TSCC_IDX_SCALE: rd_val = {4'h0, base_scale};
         `TSCC_IDX_GCFG: rd_val = global_configuration;
         `TSCC_IDX_CHEN: rd_val = channel_sample_enable;
         `TSCC_IDX_TCFG: rd_val = channel_timing_config;
         `TSCC_IDX_NOISE: rd_val = ana_flag;
         `TSCC_IDX_ISTAT: rd_val = {4'h0, int_status};
         `TSCC_IDX_IMASK: rd_val = {4'h0, int_mask};
         default: rd_val = 8'h00;
      endcase
   end

   // pin synchronisers
   always @(posedge clk_i) begin
      if (rst_i) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         wake_m <= 1'b0;
         wake_s <= 1'b0;
      end else begin
         scl_m <= scl_i;
         scl_s <= scl_m;
         sda_m <= sda_i;
         sda_s <= sda_m;
         wake_m <= wake_i;
         wake_s <= wake_m;
      end
   end

   // bus slave and configuration registers
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         base_scale <= `TSCC_RST_SCALE;
         global_configuration <= `TSCC_RST_GCFG;
         channel_sample_enable <= `TSCC_RST_CHEN;
         channel_timing_config <= `TSCC_RST_TCFG;
         int_mask <= `TSCC_RST_IMASK;
      end else begin
         wb_ack_o <= rd_req;
         // unmapped reads give zero, unmapped writes are dropped
         if (rd_req) begin
            wb_dat_o <= {24'h000000, rd_val};
         end
         if (wr_req) begin
            case (reg_idx)
               `TSCC_IDX_SCALE: base_scale <= wdat[3:0];
               `TSCC_IDX_GCFG: global_configuration <= wdat & `TSCC_GCFG_MASK;
               `TSCC_IDX_CHEN: channel_sample_enable <= wdat;
               `TSCC_IDX_TCFG: channel_timing_config <= wdat;
               `TSCC_IDX_IMASK: int_mask <= wdat[3:0];
               default: ;
            endcase
         end
      end
   end

   // interrupt status: a new event wins over a same-cycle clear
   always @* begin
      next_status = int_status;
      if (wr_req && reg_idx == `TSCC_IDX_ISTAT) begin
         next_status = int_status & ~wdat[3:0];
      end
      if (bus_to) begin
         next_status[`TSCC_IS_BUSTO] = 1'b1;
      end
      if (bus_idle) begin
         next_status[`TSCC_IS_BUSIDLE] = 1'b1;
      end
      if (|hold_recal_o) begin
         next_status[`TSCC_IS_HOLD] = 1'b1;
      end
      if (wake_exit_o) begin
         next_status[`TSCC_IS_WAKE] = 1'b1;
      end
      if (standby_i && wake_cfg && |touch_ok && !wake_drive) begin
         next_status[`TSCC_IS_WAKE] = 1'b1;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         int_status <= 4'h0;
         irq_o <= 1'b0;
      end else begin
         int_status <= next_status;
         irq_o <= |(next_status & int_mask);
      end
   end

   // wake pin: driven only on a standby touch with wake config set,
   // released when the wake config is cleared, or when software clears the wake status bit with no standby touch
   always @(posedge clk_i) begin
      if (rst_i) begin
         wake_drive <= 1'b0;
         wake_o <= 1'b0;
         wake_oe_n_o <= 1'b1;
         wake_exit_o <= 1'b0;
      end else begin
         if (standby_i && wake_cfg && |touch_ok) begin
            wake_drive <= 1'b1;
         end else if (!next_status[`TSCC_IS_WAKE] || !wake_cfg) begin
            wake_drive <= 1'b0;
         end
         wake_o <= wake_drive;
         wake_oe_n_o <= ~wake_drive;
         // external high leaves deep sleep whatever the config, unless the device is driving the wake pin itself
         wake_exit_o <= deep_sleep_i && wake_s && !wake_drive;
      end
   end

   // analog noise flag and touch qualification
   always @(posedge clk_i) begin
      if (rst_i) begin
         ana_flag <= 8'h00;
         touch_o <= 8'h00;
         recal_use_o <= 8'h00;
         ana_retry_o <= 8'h00;
         base_count_o <= 16'h0000;
      end else begin
         ana_flag <= ana_err_i;
         touch_o <= touch_ok;
         // touch path ignores base_scale entirely
         recal_use_o <= ~touch_raw_i & (~noise_raw_i | {8{dig_bypass}});
         ana_retry_o <= {8{cal_active_i}} & ana_flag & ~{8{ana_bypass}};
         if (base_scale > `TSCC_SCALE_MAX) begin
            base_count_o <= base_raw_i >> `TSCC_SCALE_MAX;
         end else begin
            base_count_o <= base_raw_i >> base_scale;
         end
      end
   end

   // millisecond tick shared by hold and repeat timers
   always @(posedge clk_i) begin
      if (rst_i) begin
         ms_cnt <= 16'h0000;
         ms_tick <= 1'b0;
      end else begin
         ms_tick <= (ms_cnt == MS_LIM);
         if (ms_cnt == MS_LIM) begin
            ms_cnt <= 16'h0000;
         end else begin
            ms_cnt <= ms_cnt + 16'h0001;
         end
      end
   end

   // fixed eight-slot sampling round; disabled channels keep their slot
   always @(posedge clk_i) begin
      if (rst_i) begin
         slot_cnt <= 16'h0000;
         slot_ch <= 3'h0;
         sample_o <= 8'h00;
      end else begin
         sample_o <= 8'h00;
         if (slot_cnt == SLOT_LIM) begin
            slot_cnt <= 16'h0000;
            slot_ch <= slot_ch + 3'h1;
         end else begin
            slot_cnt <= slot_cnt + 16'h0001;
         end
         if (slot_cnt == 16'h0000) begin
            sample_o[slot_ch] <= channel_sample_enable[slot_ch];
         end
      end
   end

   // auto repeat interval
   always @(posedge clk_i) begin
      if (rst_i) begin
         rpt_ms <= 10'h000;
         repeat_o <= 1'b0;
      end else begin
         repeat_o <= 1'b0;
         if (!auto_repeat_i || !(|touch_ok)) begin
            rpt_ms <= 10'h000;
         end else if (ms_tick) begin
            if (rpt_ms + 10'h001 >= rpt_lim) begin
               rpt_ms <= 10'h000;
               repeat_o <= 1'b1;
            end else begin
               rpt_ms <= rpt_ms + 10'h001;
            end
         end
      end
   end

   // per-channel hold timers
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : hold_ch
         reg [13:0] held_ms;
         always @(posedge clk_i) begin
            if (rst_i) begin
               held_ms <= 14'h0000;
               hold_recal_o[g] <= 1'b0;
            end else begin
               hold_recal_o[g] <= 1'b0;
               // disabled or grouped: touch may last forever
               if (!hold_en || !touch_ok[g] || grouped_i[g]) begin
                  held_ms <= 14'h0000;
               end else if (ms_tick) begin
                  if (held_ms + 14'h0001 >= hold_ms) begin
                     held_ms <= 14'h0000;
                     hold_recal_o[g] <= 1'b1;
                  end else begin
                     held_ms <= held_ms + 14'h0001;
                  end
               end
            end
         end
      end
   endgenerate

   // serial bus watch and its reset request
   tscc_bus_watch #(
      .LOW_CYCLES(BUS_LOW_CYCLES),
      .IDLE_CYCLES(BUS_IDLE_CYCLES)
   ) u_watch (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .enable_i(global_configuration[`TSCC_GCFG_TIMEOUT]),
      .scl_i(scl_s),
      .sda_i(sda_s),
      .timeout_o(bus_to),
      .idle_o(bus_idle)
   );

   always @(posedge clk_i) begin
      if (rst_i) begin
         bus_reset_o <= 1'b0;
      end else begin
         bus_reset_o <= bus_to || bus_idle;
      end
   end
endmodule // tscc_config

// File: tb/tscc_config_properties.sv
// port assertions for the touch configuration block
// assumes it is bound into tscc_config, all on clk_i
`timescale 1ns/10ps
module tscc_config_properties (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // observed ports
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire [31:0] wb_dat_o,
   input wire [7:0] touch_raw_i,
   input wire [7:0] ana_err_i,
   input wire standby_i,
   input wire deep_sleep_i,
   input wire [7:0] touch_o,
   input wire [7:0] recal_use_o,
   input wire [7:0] ana_retry_o,
   input wire [7:0] sample_o,
   input wire wake_o,
   input wire wake_oe_n_o,
   input wire wake_exit_o,
   input wire bus_reset_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_ack_once: assert property (s_req |=> s_ack) else $error("bus ack not one pulse");
   a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_touch_cause: assert property ((touch_o & ~$past(touch_raw_i)) == 8'h00)
      else $error("touch without raw touch");
   a_recal_sub: assert property ((recal_use_o & $past(touch_raw_i)) == 8'h00)
      else $error("touching sample used for recal");
   a_retry_cause: assert property ((ana_retry_o & ~$past(ana_err_i, 2)) == 8'h00)
      else $error("retry without noise flag");
   a_wake_level: assert property (!wake_oe_n_o |-> wake_o)
      else $error("wake driven low");
   a_wake_start: assert property ($fell(wake_oe_n_o) |-> $past(standby_i, 2))
      else $error("wake driven outside standby");
   a_exit_sleep: assert property (wake_exit_o |-> $past(deep_sleep_i))
      else $error("wake exit outside deep sleep");
   a_one_slot: assert property ($onehot0(sample_o))
      else $error("two channels in one slot");
   a_slot_gap: assert property (sample_o != 8'h00 |=> (sample_o == 8'h00) [*8])
      else $error("slots too close");
   a_brst_pulse: assert property (bus_reset_o |=> !bus_reset_o)
      else $error("bus reset not a pulse");
endmodule // tscc_config_properties

bind tscc_config tscc_config_properties tscc_config_properties_i (.clk_i(clk_i),
   .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .wb_dat_o(wb_dat_o), .touch_raw_i(touch_raw_i), .ana_err_i(ana_err_i),
   .standby_i(standby_i), .deep_sleep_i(deep_sleep_i), .touch_o(touch_o),
   .recal_use_o(recal_use_o), .ana_retry_o(ana_retry_o), .sample_o(sample_o),
   .wake_o(wake_o), .wake_oe_n_o(wake_oe_n_o), .wake_exit_o(wake_exit_o),
   .bus_reset_o(bus_reset_o));

// File: tb/tscc_host.sv
// classic wishbone master standing in for the host controller
// assumes a slave that answers within a few cycles
`timescale 1ns/10ps
module tscc_host (
   // clock
   input wire clk_i,
   // bus
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [3:0] wb_sel_o,
   output logic [9:0] wb_adr_o,
   output logic [31:0] wb_dat_o,
   input wire [31:0] wb_dat_i,
   input wire wb_ack_i,
   // no answer seen
   output logic hung_o
);
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o = 1'b0;
      wb_sel_o = 4'h0;
      wb_adr_o = 10'h0;
      wb_dat_o = 32'h0;
      hung_o = 1'b0;
   end
   task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd,
         output logic [31:0] rd);
      int n;
      @(posedge clk_i);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= we;
      wb_sel_o <= 4'h1;
      wb_adr_o <= {idx, 2'b00};
      wb_dat_o <= {24'h0, wd};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_i !== 1'b1 && n < 20);
      if (wb_ack_i !== 1'b1)
         hung_o = 1'b1;
      rd = wb_dat_i;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      // idle data flips so a stale value is never mistaken for a fresh one
      wb_dat_o <= ~wb_dat_o;
      @(posedge clk_i);
   endtask
endmodule // tscc_host

// File: tb/tscc_config_test.sv
// self-checking bench for the touch configuration block
// assumes shortened timing parameters: 20 cycles per ms tick
`timescale 1ns/10ps
`include "tscc_regs.vh"
module tscc_config_test;
   logic clk_i = 0, rst_i = 1, scl = 1, sda = 0, wake_ext = 0;
   logic [15:0] base_raw = 16'hf0f0;
   logic [7:0] traw = 0, nraw = 0, aerr = 0, grp = 0;
   logic cal = 1, arep = 0, stby = 0, dslp = 0;
   wire cyc, stb, we, ack, hung, wake_o, oe_n, rep, brst, wexit, irq;
   wire [3:0] sel;
   wire [9:0] adr;
   wire [31:0] wdat, rdat;
   wire [15:0] base_o;
   wire [7:0] touch, recal, retry, hold, samp;
   // wake line with pull-down: device drive wins when enabled
   wire wake_pin = !oe_n ? wake_o : wake_ext;
   int failures = 0, checks_done = 0, cyc_n = 0, rep_at = 0, rep_gap = 0;
   int hold_n = 0, samp_n = 0, brst_n = 0;
   logic [7:0] samp_or = 0;
   logic clr = 0;
   logic [31:0] rd_v;
   always #12.5 clk_i = ~clk_i;
   tscc_host tscc_host_i (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
      .wb_sel_o(sel), .wb_adr_o(adr), .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack),
      .hung_o(hung));
   tscc_config #(.BUS_LOW_CYCLES(200), .BUS_IDLE_CYCLES(50), .MS_CYCLES(20)) tscc_config_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .base_raw_i(base_raw), .touch_raw_i(traw), .noise_raw_i(nraw), .ana_err_i(aerr),
      .grouped_i(grp), .cal_active_i(cal), .auto_repeat_i(arep), .standby_i(stby),
      .deep_sleep_i(dslp), .scl_i(scl), .sda_i(sda), .wake_i(wake_pin), .wake_o(wake_o),
      .wake_oe_n_o(oe_n), .base_count_o(base_o), .touch_o(touch), .recal_use_o(recal),
      .ana_retry_o(retry), .hold_recal_o(hold), .sample_o(samp), .repeat_o(rep),
      .bus_reset_o(brst), .wake_exit_o(wexit), .irq_o(irq));
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (rep === 1'b1) begin
         rep_gap <= cyc_n - rep_at;
         rep_at <= cyc_n;
      end
      // hold and sample counters restart through clr so only this block drives them
      hold_n <= (clr ? 0 : hold_n) + (hold !== 8'h00);
      samp_n <= (clr ? 0 : samp_n) + $countones(samp);
      samp_or <= (clr ? 8'h00 : samp_or) | samp;
      brst_n <= brst_n + (brst === 1'b1);
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic xf(input logic w, input logic [7:0] idx, input logic [7:0] d);
      tscc_host_i.xfer(w, idx, d, rd_v);
      if (hung === 1'b1) begin
         failures++;
         close_out();
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      xf(1'b1, idx, d);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      xf(1'b0, idx, 8'h00);
      chk("register", rd_v, {24'h0, exp});
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic zero_counts;
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
   endtask
   task automatic t_regs;
      chk("base at reset", base_o, 16'h00f0);
      rd(8'h1f, 8'h0f);
      rd(8'h20, 8'h20);
      rd(8'h21, 8'hff);
      rd(8'h22, 8'ha4);
      wr(8'h05, 8'h77);
      rd(8'h05, 8'h00);
      wr(8'h20, 8'hff);
      rd(8'h20, 8'hf8);
      wr(8'h20, 8'h20);
      $display("test regs done");
   endtask
   task automatic t_scale;
      traw <= 8'h5a;
      for (int c = 0; c < 10; c++) begin
         wr(8'h1f, c[7:0]);
         wt(3);
         chk("base", base_o, base_raw >> (c > 8 ? 8 : c));
         chk("touch", touch, 8'h5a);
      end
      $display("test scale done");
   endtask
   task automatic t_noise;
      traw <= 8'h01;
      nraw <= 8'h03;
      wt(3);
      chk("recal bypass", recal, 8'hfe);
      wr(8'h20, 8'h00);
      wt(3);
      chk("recal noise", recal, 8'hfc);
      traw <= 8'h03;
      aerr <= 8'h02;
      wt(4);
      rd(8'h0a, 8'h02);
      chk("touch blocked", touch, 8'h01);
      chk("retry", retry, 8'h02);
      wr(8'h20, 8'h10);
      wt(4);
      chk("touch kept", touch, 8'h03);
      chk("no retry", retry, 8'h00);
      aerr <= 8'h00;
      wt(4);
      rd(8'h0a, 8'h00);
      $display("test noise done");
   endtask
   task automatic t_bus;
      wr(8'h20, 8'h20);
      wr(8'h31, 8'h03);
      scl <= 1'b0;
      wt(300);
      scl <= 1'b1;
      sda <= 1'b1;
      wt(100);
      sda <= 1'b0;
      rd(8'h30, 8'h00);
      chk("no bus reset", brst_n, 0);
      wr(8'h20, 8'ha0);
      scl <= 1'b0;
      wt(150);
      rd(8'h30, 8'h00);
      wt(150);
      rd(8'h30, 8'h01);
      chk("timeout reset", brst_n, 1);
      chk("irq", irq, 1'b1);
      wr(8'h30, 8'h01);
      rd(8'h30, 8'h00);
      chk("irq cleared", irq, 1'b0);
      scl <= 1'b1;
      sda <= 1'b1;
      wt(100);
      sda <= 1'b0;
      rd(8'h30, 8'h02);
      chk("bus reset", brst_n, 2);
      wr(8'h31, 8'h00);
      wt(2);
      chk("irq masked", irq, 1'b0);
      wr(8'h20, 8'h20);
      wr(8'h30, 8'hff);
      $display("test bus done");
   endtask
   task automatic t_wake;
      traw <= 8'h01;
      stby <= 1'b1;
      wt(5);
      chk("wake idle", oe_n, 1'b1);
      wr(8'h20, 8'h60);
      wt(3);
      chk("wake drive", {oe_n, wake_o}, 2'b01);
      traw <= 8'h00;
      stby <= 1'b0;
      wr(8'h20, 8'h20);
      wr(8'h30, 8'h08);
      wt(3);
      chk("wake released", oe_n, 1'b1);
      dslp <= 1'b1;
      wake_ext <= 1'b1;
      wt(6);
      chk("wake exit", wexit, 1'b1);
      dslp <= 1'b0;
      wake_ext <= 1'b0;
      wr(8'h30, 8'hff);
      $display("test wake done");
   endtask
   task automatic t_hold;
      int n;
      wr(8'h22, 8'h04);
      traw <= 8'h01;
      zero_counts();
      wt(11500);
      chk("no hold recal", hold_n, 0);
      wr(8'h20, 8'h28);
      n = 0;
      while (hold === 8'h00 && n < 11300) begin
         @(posedge clk_i);
         n++;
      end
      chk("hold recal", hold, 8'h01);
      if (hold === 8'h00) begin
         failures++;
         close_out();
      end
      grp <= 8'h01;
      wt(2);
      zero_counts();
      wt(11500);
      chk("grouped", hold_n, 0);
      traw <= 8'h00;
      wr(8'h20, 8'h20);
      $display("test hold done");
   endtask
   task automatic t_repeat;
      traw <= 8'h01;
      arep <= 1'b1;
      for (int c = 0; c < 3; c += 2) begin
         wr(8'h22, c[7:0]);
         wt((c + 1) * 2100);
         chk("repeat gap", rep_gap, (c + 1) * 700);
      end
      arep <= 1'b0;
      traw <= 8'h00;
      $display("test repeat done");
   endtask
   task automatic t_sample;
      logic [7:0] en [2] = '{8'h05, 8'hff};
      for (int i = 0; i < 2; i++) begin
         wr(8'h21, en[i]);
         wt(300);
         zero_counts();
         wt(2048);
         chk("sampled set", samp_or, en[i]);
         chk("sample count", samp_n, $countones(en[i]));
      end
      $display("test sample done");
   endtask
   initial begin
      wt(16);
      rst_i <= 1'b0;
      wt(2);
      t_regs();
      t_scale();
      t_noise();
      t_bus();
      t_wake();
      t_hold();
      t_repeat();
      t_sample();
      close_out();
   end
endmodule // tscc_config_test
